// ===== core/erc_core.sv
// Emergency reverse supervisor for a speed-controlled traction drive.
// Assumes synchronous operator inputs, a signed measured motor speed and one clock.
// How it works
// - Act only with the enable option set.
// - Source select picks switch or software request.
// - Selects 2 and 3 need forward travel.
// - Inhibit driving until inputs released after.
// - Time the reverse once moving backward.
// - Forward motion restarts the duration timer.
// - Maximum limit value never times out.
// - Timer expiry sets the timeout fault.
// - Fault clears only on input recycle.
// - Zero limit only stops the vehicle.
// - Reverse speed capped by smaller maximum.
// - Never active in torque control mode.
// - Reverse acceleration uses the accel rate.
// - Slow reverse rises at accel rate.
// - Forward motion brakes at decel rate.
// - Fast reverse slows at decel rate.
`timescale 1ns/1ps
`include "erc_params.svh"
module erc_core #(
  parameter int unsigned TICK_CYCLES = `ERC_LIMIT_TICK_NS / `ERC_CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 ce_i,
  // Register port
  input  wire logic [15:0]          reg_addr_i,
  input  wire logic [15:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [15:0]          reg_rdata_o,
  // Operator and drive inputs
  input  wire erc_pkg::erc_oper_t   oper_i,
  input  wire logic                 torque_mode_i,
  input  wire logic                 express_mode_i,
  input  wire logic [15:0]          express_mode_max_speed_i,
  input  wire logic [15:0]          speed_mode_max_speed_i,
  input  wire logic signed [15:0]   motor_speed_i,
  // Command and status outputs
  output erc_pkg::erc_cmd_t         cmd_o,
  output logic                      drive_inhibit_o,
  output logic                      timeout_fault_o,
  output logic                      irq_o
);
  import erc_pkg::*;

  localparam int unsigned RAMP_CYCLES = `ERC_RAMP_TICK_NS / `ERC_CLK_PERIOD_NS;

  // Rate for the ramp: shrinking magnitude brakes, growing one accelerates
  function automatic logic [15:0] ramp_rate(input logic signed [15:0] cur,
                                            input logic signed [15:0] tgt,
                                            input logic [15:0] acc_r,
                                            input logic [15:0] dec_r);
    logic shrink;
    shrink = (cur > tgt) ? (cur > 16'sh0000) : (cur < 16'sh0000);
    ramp_rate = shrink ? dec_r : acc_r;
  endfunction

  // Software registers
  logic [7:0]  src_sel_ff;   // Activation source select
  logic [15:0] cap_ff;       // Reverse speed cap
  logic [15:0] accel_ff;     // Reverse acceleration rate
  logic [15:0] decel_ff;     // Braking rate
  logic [15:0] limit_ff;     // Reverse time limit
  logic [15:0] opt_ff;       // Option bits one
  logic [7:0]  dil_ff;       // Release interlock configuration
  logic        swreq_ff;     // Software activation request
  logic [2:0]  irq_en_ff;    // Interrupt enables
  logic [2:0]  irq_st_ff;    // Sticky interrupt status
  logic [15:0] rdata_ff;     // Read data, one cycle late
  // Control state
  erc_state_t  st_ff;        // Supervisor state
  logic        req_d_ff;     // Request delayed, for edge detect
  logic        fault_ff;     // Timeout fault
  logic signed [15:0] cmd_ff; // Commanded speed
  logic [25:0] racc_ff;      // Ramp accumulator
  logic [7:0]  rpre_ff;      // Microsecond prescaler
  logic [31:0] tpre_ff;      // Limit tick prescaler
  logic [15:0] lcnt_ff;      // Elapsed limit counts

  // Combinational helpers
  logic        req;          // Selected activation request
  logic        req_rise;     // Request just asserted
  logic        fwd_only;     // Forward travel required
  logic        start;        // Begin emergency reverse
  logic        released;     // Operator inputs cleared
  logic        expire;       // Duration timer ran out
  logic        rtick;        // Ramp step opportunity
  logic [15:0] mode_max;     // Maximum of the selected drive mode
  logic [15:0] cap_eff;      // Smaller of the two caps
  logic signed [15:0] tgt;   // Ramp target
  logic [25:0] thr;          // Accumulator threshold

  // Request path: source pick, edge detect, then the gates that let an event start
  assign req      = src_sel_ff[`ERC_BIT_SRC_SW] ? swreq_ff : oper_i.sw_one;
  assign fwd_only = src_sel_ff[`ERC_BIT_SRC_FWD];
  assign req_rise = req & ~req_d_ff;
  assign start    = (st_ff == ERC_IDLE) && req_rise && opt_ff[`ERC_BIT_ENABLE]
                    && !torque_mode_i
                    && (!fwd_only || motor_speed_i > 16'sh0000);
  // With the interlock option the interlock switch must open too
  assign released = !oper_i.throttle && !oper_i.direction &&
                    (!dil_ff[`ERC_BIT_DIR_ILOCK] || !oper_i.interlock);
  // Reverse target: the smaller maximum, or a plain stop with a zero limit
  assign mode_max = express_mode_i ? express_mode_max_speed_i : speed_mode_max_speed_i;
  assign cap_eff  = (cap_ff < mode_max) ? cap_ff : mode_max;
  assign tgt      = (limit_ff == `ERC_RST_ZERO) ? 16'sh0000 : -$signed(cap_eff);
  // Expiry is suppressed at both ends of the limit range
  assign expire   = (st_ff == ERC_ACTIVE) && (limit_ff != `ERC_RST_ZERO)
                    && (limit_ff != `ERC_LIMIT_MAX) && (lcnt_ff >= limit_ff);
  // Ramp pacing: one step opportunity per microsecond
  assign rtick    = (rpre_ff == 8'(RAMP_CYCLES - 1));
  assign thr      = {10'h000, ramp_rate(cmd_ff, tgt, accel_ff, decel_ff)} * `ERC_RATE_UNIT;

  // Register writes; software command bits pair as on and off
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_sel_ff <= 8'h00;
      cap_ff     <= `ERC_RST_SPEED_CAP;
      accel_ff   <= `ERC_RST_RATE;
      decel_ff   <= `ERC_RST_RATE;
      limit_ff   <= `ERC_RST_ZERO;
      opt_ff     <= `ERC_RST_ZERO;
      dil_ff     <= 8'h00;
      swreq_ff   <= 1'b0;
      irq_en_ff  <= 3'h0;
    end else if (ce_i && reg_wr_i) begin
      case (reg_addr_i)
        `ERC_OFS_SRC_SEL:    src_sel_ff <= reg_wdata_i[7:0];
        `ERC_OFS_SPEED_CAP:  cap_ff     <= reg_wdata_i;
        `ERC_OFS_ACCEL_RATE: accel_ff   <= reg_wdata_i;
        `ERC_OFS_DECEL_RATE: decel_ff   <= reg_wdata_i;
        `ERC_OFS_TIME_LIMIT: limit_ff   <= reg_wdata_i;
        `ERC_OFS_OPTION_ONE: opt_ff     <= reg_wdata_i;
        `ERC_OFS_DIR_ILOCK:  dil_ff     <= reg_wdata_i[7:0];
        `ERC_OFS_IRQ_ENABLE: irq_en_ff  <= reg_wdata_i[2:0];
        // Off wins when both command bits are written together
        `ERC_OFS_SW_CMD: begin
          if (reg_wdata_i[`ERC_BIT_SW_OFF]) begin
            swreq_ff <= 1'b0;
          end else if (reg_wdata_i[`ERC_BIT_SW_ON]) begin
            swreq_ff <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // Register reads; unmapped and write-only offsets read zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= 16'h0000;
    end else if (ce_i) begin
      rdata_ff <= 16'h0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `ERC_OFS_SRC_SEL:    rdata_ff <= {8'h00, src_sel_ff};
          `ERC_OFS_SPEED_CAP:  rdata_ff <= cap_ff;
          `ERC_OFS_ACCEL_RATE: rdata_ff <= accel_ff;
          `ERC_OFS_DECEL_RATE: rdata_ff <= decel_ff;
          `ERC_OFS_TIME_LIMIT: rdata_ff <= limit_ff;
          `ERC_OFS_OPTION_ONE: rdata_ff <= opt_ff;
          `ERC_OFS_DIR_ILOCK:  rdata_ff <= {8'h00, dil_ff};
          `ERC_OFS_SW_CMD:     rdata_ff <= {15'h0000, swreq_ff};
          `ERC_OFS_STATUS:     rdata_ff <= {12'h000, st_ff, fault_ff, req};
          `ERC_OFS_IRQ_STATUS: rdata_ff <= {13'h0000, irq_st_ff};
          `ERC_OFS_IRQ_ENABLE: rdata_ff <= {13'h0000, irq_en_ff};
          default:             rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  // Supervisor state machine
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff    <= ERC_IDLE;
      req_d_ff <= 1'b0;
    end else if (ce_i) begin
      req_d_ff <= req;
      case (st_ff)
        ERC_IDLE: begin
          if (start) begin
            st_ff <= ERC_ACTIVE;
          end
        end
        // Dropping the request, a timeout or torque mode all end the event
        ERC_ACTIVE: begin
          if (!req || expire || torque_mode_i) begin
            st_ff <= ERC_INHIBIT;
          end
        end
        ERC_INHIBIT: begin
          if (released) begin
            st_ff <= ERC_IDLE;
          end
        end
        default: st_ff <= ERC_IDLE;
      endcase
    end
  end

  // Timeout fault: expiry sets it, a fresh request edge clears it; set wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_ff <= 1'b0;
    end else if (ce_i) begin
      if (expire) begin
        fault_ff <= 1'b1;
      end else if (req_rise) begin
        fault_ff <= 1'b0;
      end
    end
  end

  // Duration timer counts only while reversing; forward travel restarts it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tpre_ff <= 32'h0000_0000;
      lcnt_ff <= 16'h0000;
    end else if (ce_i) begin
      if (st_ff != ERC_ACTIVE || motor_speed_i > 16'sh0000) begin
        tpre_ff <= 32'h0000_0000;
        lcnt_ff <= 16'h0000;
      end else if (motor_speed_i < 16'sh0000) begin
        if (tpre_ff >= 32'(TICK_CYCLES - 1)) begin
          tpre_ff <= 32'h0000_0000;
          lcnt_ff <= (lcnt_ff == 16'hFFFF) ? lcnt_ff : lcnt_ff + 16'h0001;
        end else begin
          tpre_ff <= tpre_ff + 32'h0000_0001;
        end
      end
    end
  end

  // Microsecond prescaler paces the ramp
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rpre_ff <= 8'h00;
    end else if (ce_i) begin
      rpre_ff <= rtick ? 8'h00 : rpre_ff + 8'h01;
    end
  end

  // Speed ramp: full scale is covered in the selected rate, one rpm a step.
  // Loading the measured speed at start avoids a jump in the command.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_ff  <= 16'sh0000;
      racc_ff <= 26'h000_0000;
    end else if (ce_i) begin
      if (start) begin
        cmd_ff  <= motor_speed_i;
        racc_ff <= 26'h000_0000;
      end else if (st_ff == ERC_ACTIVE && expire) begin
        cmd_ff  <= 16'sh0000;
      end else if (st_ff == ERC_ACTIVE && rtick && cmd_ff != tgt) begin
        if (racc_ff + `ERC_RAMP_FULL_SCALE >= thr) begin
          racc_ff <= racc_ff + `ERC_RAMP_FULL_SCALE - thr;
          if (cmd_ff > tgt) begin
            cmd_ff <= cmd_ff - 16'sh0001;
          end else begin
            cmd_ff <= cmd_ff + 16'sh0001;
          end
        end else begin
          racc_ff <= racc_ff + `ERC_RAMP_FULL_SCALE;
        end
      end
    end
  end

  // Sticky interrupt status: 0 start, 1 timeout, 2 drive released; set wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_st_ff <= 3'h0;
    end else if (ce_i) begin
      irq_st_ff <= (irq_st_ff &
                    ~((reg_wr_i && reg_addr_i == `ERC_OFS_IRQ_CLEAR) ? reg_wdata_i[2:0]
                                                                     : 3'h0))
                   | {st_ff == ERC_INHIBIT && released, expire, start};
    end
  end

  // Outputs
  assign reg_rdata_o     = rdata_ff;
  assign cmd_o.active    = (st_ff == ERC_ACTIVE);
  assign cmd_o.speed     = cmd_ff;
  assign drive_inhibit_o = (st_ff == ERC_INHIBIT);
  assign timeout_fault_o = fault_ff;
  assign irq_o           = |(irq_st_ff & irq_en_ff);

  // Checks; a frozen clock enable suspends them.
  // They watch internal state rather than pins, so they stay exact
  // whatever the far side does with the command. A user must note that
  // the ramp moves one rpm per step at most, so very fast rates saturate
  // at the step pace rather than the programmed figure.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i || !ce_i);

  enable_gate_a: assert property ((st_ff == ERC_IDLE) && !opt_ff[`ERC_BIT_ENABLE]
    |=> st_ff != ERC_ACTIVE) else $error("started while disabled");
  fwd_only_a: assert property ((st_ff == ERC_IDLE) && fwd_only
    && motor_speed_i <= 16'sh0000 |=> st_ff != ERC_ACTIVE) else $error("forward gate broken");
  torque_block_a: assert property (torque_mode_i |=> st_ff != ERC_ACTIVE)
    else $error("active in torque mode");
  inhibit_hold_a: assert property ((st_ff == ERC_INHIBIT) && !released
    |=> st_ff == ERC_INHIBIT) else $error("inhibit left early");
  timer_restart_a: assert property ((st_ff == ERC_ACTIVE) && motor_speed_i > 16'sh0000
    |=> lcnt_ff == 16'h0000 && tpre_ff == 32'h0000_0000) else $error("timer not restarted");
  no_timeout_a: assert property (limit_ff == `ERC_LIMIT_MAX |-> !expire)
    else $error("timeout at max limit");
  fault_set_a: assert property (expire |=> timeout_fault_o ##1 (timeout_fault_o || $past(req_rise)))
    else $error("fault not set");
  fault_hold_a: assert property (timeout_fault_o && !req_rise |=> timeout_fault_o)
    else $error("fault cleared without recycle");
  stop_only_a: assert property ((st_ff == ERC_ACTIVE) && limit_ff == `ERC_RST_ZERO
    && !reg_wr_i && cmd_ff >= 16'sh0000 |=> cmd_ff >= 16'sh0000) else $error("reversed at zero limit");
  speed_cap_a: assert property ((st_ff == ERC_ACTIVE) && !start && cmd_ff >= tgt
    |=> cmd_ff >= $past(tgt)) else $error("reverse speed over cap");
  ramp_pace_a: assert property ((st_ff == ERC_ACTIVE) && !rtick && !expire
    |=> $stable(cmd_ff)) else $error("ramp stepped off tick");


  // Starting loads the measured speed so the command does not jump
  start_load_a: assert property (start
    |=> st_ff == ERC_ACTIVE && cmd_ff == $past(motor_speed_i))
    else $error("start did not load speed");

  // A timeout ends the event and drops the command to rest
  expire_end_a: assert property (expire
    |=> st_ff == ERC_INHIBIT && cmd_ff == 16'sh0000)
    else $error("timeout did not end event");

  // A zero limit never reverses and never times out
  zero_limit_a: assert property (limit_ff == `ERC_RST_ZERO
    |-> !expire && tgt == 16'sh0000)
    else $error("zero limit drives reverse");

  // Released inputs end the inhibit in one cycle
  release_exit_a: assert property ((st_ff == ERC_INHIBIT) && released
    |=> st_ff == ERC_IDLE)
    else $error("inhibit not released");

  // A qualified request edge always starts an event
  req_taken_a: assert property ((st_ff == ERC_IDLE) && req_rise && opt_ff[`ERC_BIT_ENABLE]
    && !torque_mode_i && !fwd_only |=> st_ff == ERC_ACTIVE)
    else $error("request not taken");

  // The duration timer is held at zero outside an event
  timer_idle_a: assert property (st_ff != ERC_ACTIVE
    |=> lcnt_ff == 16'h0000)
    else $error("timer ran outside event");

  // The ramp moves the command by one rpm at most per cycle
  ramp_step_a: assert property ((st_ff == ERC_ACTIVE) && !expire
    |=> cmd_ff == $past(cmd_ff) || cmd_ff == $past(cmd_ff) + 16'sh0001
    || cmd_ff == $past(cmd_ff) - 16'sh0001) else $error("ramp step too large");

  // Torque mode ends a running event
  torque_end_a: assert property ((st_ff == ERC_ACTIVE) && torque_mode_i
    |=> st_ff == ERC_INHIBIT) else $error("torque mode did not end event");

  // A fresh request edge clears the fault
  fault_clear_a: assert property (timeout_fault_o && req_rise && !expire
    |=> !timeout_fault_o) else $error("fault not cleared on recycle");

  start_c:    cover property (start);
  timeout_c:  cover property (expire ##1 timeout_fault_o);
  release_c:  cover property ((st_ff == ERC_INHIBIT) ##1 (st_ff == ERC_IDLE));
  // Forward motion in mid-event and a fast reverse slowing to the cap
  restart_c:  cover property ((st_ff == ERC_ACTIVE) && motor_speed_i > 16'sh0000
    && lcnt_ff != 16'h0000);
  slowdown_c: cover property ((st_ff == ERC_ACTIVE) && rtick && cmd_ff < tgt);
endmodule // erc_core

// ===== pkg/erc_params.svh
// Constants for the emergency reverse supervisor: offsets, fields, resets, timing.
// Assumes a 200 MHz control clock and a 16-bit register address space.
`ifndef ERC_PARAMS_SVH
`define ERC_PARAMS_SVH
// Register offsets, as seen on the register port
`define ERC_OFS_SRC_SEL      16'h3036
`define ERC_OFS_SPEED_CAP    16'h3038
`define ERC_OFS_ACCEL_RATE   16'h3039
`define ERC_OFS_DECEL_RATE   16'h303A
`define ERC_OFS_TIME_LIMIT   16'h303B
`define ERC_OFS_OPTION_ONE   16'h306A
`define ERC_OFS_DIR_ILOCK    16'h389F
`define ERC_OFS_SW_CMD       16'h3F00
`define ERC_OFS_STATUS       16'h3F01
`define ERC_OFS_IRQ_STATUS   16'h3F02
`define ERC_OFS_IRQ_CLEAR    16'h3F03
`define ERC_OFS_IRQ_ENABLE   16'h3F04
// Field positions
`define ERC_BIT_ENABLE       1
`define ERC_BIT_DIR_ILOCK    0
`define ERC_BIT_SW_ON        0
`define ERC_BIT_SW_OFF       1
`define ERC_BIT_SRC_SW       0
`define ERC_BIT_SRC_FWD      1
// Reset values
`define ERC_RST_SPEED_CAP    16'h0032
`define ERC_RST_RATE         16'h0064
`define ERC_RST_ZERO         16'h0000
// Time limit: one count is 8 ms, top count means no timeout
`define ERC_LIMIT_MAX        16'h0EA6
`define ERC_LIMIT_TICK_NS    8000000
`define ERC_CLK_PERIOD_NS    5
// Ramp: rates are ms per full scale, stepped once per microsecond at most
`define ERC_RAMP_TICK_NS     1000
`define ERC_RAMP_FULL_SCALE  26'd6000
`define ERC_RATE_UNIT        26'd1000
`endif

// ===== pkg/erc_pkg.sv
// Types shared by the emergency reverse supervisor and its surroundings.
// Assumes nothing beyond a SystemVerilog tool.
package erc_pkg;
  // Operator inputs, sampled as synchronous levels
  typedef struct packed {
    logic sw_one;     // Hardware emergency reverse switch
    logic interlock;  // Interlock switch closed
    logic throttle;   // Throttle away from neutral
    logic direction;  // A direction is selected
  } erc_oper_t;
  // Speed command toward the motor speed loop
  typedef struct packed {
    logic               active; // Emergency reverse owns the command
    logic signed [15:0] speed;  // Forward positive, rpm
  } erc_cmd_t;
  // Supervisor states
  typedef enum logic [1:0] {
    ERC_IDLE    = 2'b00,
    ERC_ACTIVE  = 2'b01,
    ERC_INHIBIT = 2'b10
  } erc_state_t;
endpackage

// ===== test/erc_motor_model.sv
// Far-side model: motor speed feedback that follows the supervisor's command.
// Assumes the command is obeyed one cycle late; the bench may pin the speed.
`timescale 1ns/1ps
module erc_motor_model (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  // Command and bench control
  input  wire erc_pkg::erc_cmd_t  cmd_i,
  input  wire logic               hold_i,
  input  wire logic signed [15:0] set_speed_i,
  // Measured speed
  output logic signed [15:0]      motor_speed_o
);
  import erc_pkg::*;
  // Follow the owned command, else coast at the bench speed
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      motor_speed_o <= 16'sh0000;
    end else if (hold_i || !cmd_i.active) begin  // Pinning allows forward motion mid-event
      motor_speed_o <= set_speed_i;
    end else begin
      motor_speed_o <= cmd_i.speed;
    end
  end
endmodule // erc_motor_model

// ===== test/test_emergency_reverse_control.sv
// Self-checking bench for the emergency reverse supervisor.
// Assumes erc_core, erc_pkg and the motor model; one 200 MHz clock.
`timescale 1ns/1ps
`include "erc_params.svh"
module test_emergency_reverse_control;
  import erc_pkg::*;
  // Design-facing signals
  logic               clk_i = 1'b0;
  logic               resetn_i = 1'b0;
  logic [15:0]        reg_addr_i = 16'h0000;
  logic [15:0]        reg_wdata_i = 16'h0000;
  logic               reg_wr_i = 1'b0;
  logic               reg_rd_i = 1'b0;
  logic [15:0]        reg_rdata_o;
  erc_oper_t          oper_i = '0;
  logic               torque_mode_i = 1'b0;
  logic               express_mode_i = 1'b0;
  logic signed [15:0] motor_speed;
  erc_cmd_t           cmd_o;
  logic               drive_inhibit_o;
  logic               timeout_fault_o;
  logic               irq_o;
  // Motor model control; pinned until a scenario lets it follow
  logic               hold = 1'b1;
  logic signed [15:0] set_speed = 16'sh0000;
  // Verdict counters and read result
  int                 n_fail = 0;
  int                 n_compared = 0;
  logic [15:0]        rd_val;
  // Register offsets and their reset values
  logic [15:0] ofs [7] = '{`ERC_OFS_SRC_SEL, `ERC_OFS_SPEED_CAP, `ERC_OFS_ACCEL_RATE,
    `ERC_OFS_DECEL_RATE, `ERC_OFS_TIME_LIMIT, `ERC_OFS_OPTION_ONE, `ERC_OFS_DIR_ILOCK};
  logic [15:0] rst [7] = '{16'h0000, 16'h0032, 16'h0064, 16'h0064, 16'h0000, 16'h0000,
    16'h0000};

  // Short tick keeps timer scenarios brief
  erc_core #(.TICK_CYCLES(2)) dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .oper_i(oper_i),
    .torque_mode_i(torque_mode_i), .express_mode_i(express_mode_i),
    .express_mode_max_speed_i(16'h0001), .speed_mode_max_speed_i(16'h0002),
    .motor_speed_i(motor_speed), .cmd_o(cmd_o), .drive_inhibit_o(drive_inhibit_o),
    .timeout_fault_o(timeout_fault_o), .irq_o(irq_o));

  erc_motor_model motor_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .cmd_i(cmd_o), .hold_i(hold),
    .set_speed_i(set_speed), .motor_speed_o(motor_speed));

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // Compare and count
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Let edges pass, then sample settled outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // One-cycle read strobe; data stands only in the following cycle
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd_val = reg_rdata_o;
  endtask
  // Switch-one level, changed just after an edge
  task automatic sw(input logic v);
    @(posedge clk_i);
    oper_i.sw_one <= v;
  endtask
  // Verdict, reached from the main sequence or the watchdog
  task automatic report_and_stop();
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the tests need about 38k cycles
  initial begin
    #(80000 * 5);
    n_fail++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk(rd_val, rst[i]);
    end
    rd(16'h3F10);
    chk(rd_val, 17'h0_0000);
    // Disabled: a switch request is ignored
    sw(1'b1);
    cyc(4);
    chk(cmd_o.active, 1'b0);
    sw(1'b0);
    wr(`ERC_OFS_OPTION_ONE, 16'h0002);
    wr(`ERC_OFS_IRQ_ENABLE, 16'h0001);
    wr(`ERC_OFS_DIR_ILOCK, 16'h0001);
    // Forward travel, zero limit: brake to a stop only
    @(posedge clk_i);
    set_speed <= 16'sd3;
    oper_i.throttle  <= 1'b1;
    oper_i.interlock <= 1'b1;
    sw(1'b1);
    cyc(3);
    chk({cmd_o.active, cmd_o.speed}, {1'b1, 16'sd3});
    chk(irq_o, 1'b1);
    @(posedge clk_i);
    hold <= 1'b0;
    cyc(3650);
    chk(cmd_o.speed, 16'sd2);
    cyc(12000);
    chk(cmd_o.speed, 16'sd0);
    rd(`ERC_OFS_IRQ_STATUS);
    chk(rd_val & 16'h0001, 16'h0001);
    wr(`ERC_OFS_IRQ_CLEAR, 16'h0001);
    cyc(1);
    chk(irq_o, 1'b0);
    // Release needs throttle, direction and interlock cleared
    sw(1'b0);
    cyc(3);
    chk(drive_inhibit_o, 1'b1);
    @(posedge clk_i);
    oper_i.throttle <= 1'b0;
    cyc(3);
    chk(drive_inhibit_o, 1'b1);
    @(posedge clk_i);
    oper_i.interlock <= 1'b0;
    hold <= 1'b1;
    cyc(3);
    chk(drive_inhibit_o, 1'b0);
    // Torque mode blocks activation
    torque_mode_i <= 1'b1;
    sw(1'b1);
    cyc(4);
    chk(cmd_o.active, 1'b0);
    sw(1'b0);
    torque_mode_i <= 1'b0;
    // Software source with forward check, reversing: ignored
    wr(`ERC_OFS_SRC_SEL, 16'hFF03);
    set_speed <= -16'sd5;
    wr(`ERC_OFS_SW_CMD, 16'h0001);
    cyc(3);
    chk(cmd_o.active, 1'b0);
    wr(`ERC_OFS_SW_CMD, 16'h0002);
    set_speed <= 16'sd5;
    wr(`ERC_OFS_SW_CMD, 16'h0001);
    cyc(3);
    chk(cmd_o.active, 1'b1);
    wr(`ERC_OFS_SW_CMD, 16'h0002);
    cyc(3);
    chk(cmd_o.active, 1'b0);
    // Switch source with forward check, reversing: ignored
    wr(`ERC_OFS_SRC_SEL, 16'hFF02);
    rd(`ERC_OFS_SRC_SEL);
    chk(rd_val, 16'h0002);
    set_speed <= -16'sd5;
    sw(1'b1);
    cyc(3);
    chk(cmd_o.active, 1'b0);
    sw(1'b0);
    // Plain software source acts while reversing
    wr(`ERC_OFS_SRC_SEL, 16'h0001);
    wr(`ERC_OFS_SW_CMD, 16'h0001);
    cyc(3);
    chk(cmd_o.active, 1'b1);
    wr(`ERC_OFS_SW_CMD, 16'h0002);
    // Duration timer: forward motion restarts it, expiry faults
    wr(`ERC_OFS_SRC_SEL, 16'h0000);
    wr(`ERC_OFS_TIME_LIMIT, 16'h0014);
    sw(1'b1);
    cyc(20);
    @(posedge clk_i);
    set_speed <= 16'sd5;
    cyc(30);
    @(posedge clk_i);
    set_speed <= -16'sd5;
    cyc(30);
    chk(timeout_fault_o, 1'b0);
    cyc(60);
    chk({timeout_fault_o, cmd_o.active}, 2'b10);
    rd(`ERC_OFS_IRQ_STATUS);
    chk(rd_val & 16'h0002, 16'h0002);
    sw(1'b0);
    cyc(3);
    chk(timeout_fault_o, 1'b1);
    sw(1'b1);
    cyc(3);
    chk(timeout_fault_o, 1'b0);
    sw(1'b0);
    // From rest: reverse capped by the speed mode maximum, never times out
    wr(`ERC_OFS_TIME_LIMIT, 16'h0EA6);
    set_speed <= 16'sd0;
    sw(1'b1);
    hold <= 1'b0;
    cyc(10500);
    chk(cmd_o.speed, -16'sd2);
    cyc(8000);
    chk({timeout_fault_o, cmd_o.speed}, {1'b0, -16'sd2});
    sw(1'b0);
    hold <= 1'b1;
    // Fast reverse slows one step toward the express mode maximum
    set_speed <= -16'sd3;
    express_mode_i <= 1'b1;
    cyc(3);
    sw(1'b1);
    hold <= 1'b0;
    cyc(3650);
    chk(cmd_o.speed, -16'sd2);
    sw(1'b0);
    wr(`ERC_OFS_IRQ_ENABLE, 16'h0000);
    cyc(1);
    chk(irq_o, 1'b0);
    report_and_stop();
  end
endmodule // test_emergency_reverse_control
